// ### hdl/efd_pkg.sv
// Purpose: Shared constants and types of the auxiliary FIFO transfer engine
// Assumes: One card clock, registers reached by their printed index
// Notes:   Byte counts are 32 bits wide; one FIFO word is four bytes
package efd_pkg;
   ////////////////////////////////////////////////////////////////////////
   // Register indices as seen on the register port
   localparam logic [7:0] CMD_IDX = 8'h64;
   localparam logic [7:0] STATUS_IDX = 8'h6e;
   localparam logic [7:0] SLOW_ULEN_IDX = 8'hd2;
   localparam logic [7:0] SLOW_UPOS_IDX = 8'hd3;
   localparam logic [7:0] SLOW_FREED_IDX = 8'hd4;
   localparam logic [7:0] STAMP_ULEN_IDX = 8'hdc;
   localparam logic [7:0] STAMP_UPOS_IDX = 8'hdd;
   localparam logic [7:0] STAMP_FREED_IDX = 8'hde;
   localparam logic [7:0] SLOW_BUFLEN_IDX = 8'he0;
   localparam logic [7:0] STAMP_BUFLEN_IDX = 8'he1;
   localparam logic [7:0] NOTIFY_IDX = 8'he2;
   localparam logic [7:0] TIMEOUT_IDX = 8'he3;
   localparam logic [7:0] AUX_STATE_IDX = 8'he4;

   ////////////////////////////////////////////////////////////////////////
   // Command and status bit positions
   localparam int START_BIT = 20;
   localparam int WAIT_BIT = 21;
   localparam int STOP_BIT = 22;
   localparam int POLL_BIT = 23;
   localparam logic [31:0] CMD_AUX_MASK = 32'h00f0_0000;
   localparam int BLK_BIT = 12;
   localparam int END_BIT = 13;
   localparam int OVR_BIT = 14;
   localparam int ERR_BIT = 15;
   localparam logic [31:0] STAT_AUX_MASK = 32'h0000_f000;

   ////////////////////////////////////////////////////////////////////////
   // Reset values, sizes and timing
   localparam logic [31:0] NOTIFY_RST = 32'h0000_1000;
   localparam logic [31:0] BUFLEN_RST = 32'h0000_0000;
   localparam logic [31:0] TIMEOUT_RST = 32'h0000_0000;
   localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned TIMEOUT_UNIT_NS = 1000000;
   localparam int unsigned MS_CYCLES = TIMEOUT_UNIT_NS / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      EFD_IDLE = 2'b00,
      EFD_DMA = 2'b01,
      EFD_POLL = 2'b10,
      EFD_HALT = 2'b11
   } efd_state_t;

   // Word from the shared auxiliary FIFO; kind 0 slow samples, 1 stamps
   typedef struct packed {
      logic kind;
      logic last;
      logic [31:0] data;
   } efd_word_t;

   // One card-to-host write toward the host ring buffer
   typedef struct packed {
      logic valid;
      logic kind;
      logic last;
      logic [31:0] pos;
      logic [31:0] data;
   } efd_wr_t;
endpackage

// ### hdl/efd_ring_ch.sv
// Purpose: Byte bookkeeping of one host ring buffer (one data kind)
// Assumes: Freed lengths are whole words and never exceed the user length
// Notes:   Reported length moves in notify steps, by flush at the end with zero notify, or by drain when polling
`timescale 1ns/10ps
`default_nettype none
module efd_ring_ch (
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   input wire logic start_in,
   input wire logic poll_in,
   input wire logic take_in,
   input wire logic land_in,
   input wire logic flush_in,
   input wire logic drain_in,
   input wire logic free_in,
   input wire logic [31:0] buf_len_in,
   input wire logic [31:0] notify_in,
   input wire logic [31:0] free_len_in,
   output logic [31:0] wr_pos_out,
   output logic [31:0] user_len_out,
   output logic [31:0] user_pos_out,
   output logic [31:0] drain_len_out,
   output logic space_out
);
   logic [31:0] pend_r;
   logic [31:0] free_r;
   logic [31:0] pend_up;
   logic [31:0] step;
   logic [31:0] wr_adv;
   logic [31:0] pos_adv;
   logic [31:0] freed;

   ////////////////////////////////////////////////////////////////////////
   // Landed bytes wait in pend_r until they may be reported
   assign pend_up = pend_r + (land_in ? efd_pkg::WORD_BYTES : 32'h0000_0000);
   assign freed = free_in ? free_len_in : 32'h0000_0000;
   assign drain_len_out = user_len_out + pend_r;
   assign space_out = free_r >= efd_pkg::WORD_BYTES;

   always_comb begin
      if (poll_in) begin
         step = drain_in ? pend_r : 32'h0000_0000;
      end else if (notify_in != 32'h0000_0000) begin
         step = (pend_up >= notify_in) ? notify_in : 32'h0000_0000;
      end else begin
         step = flush_in ? pend_up : 32'h0000_0000;
      end
   end

   // Ring wrap of write and user positions
   assign wr_adv = (wr_pos_out + efd_pkg::WORD_BYTES >= buf_len_in) ?
                   32'h0000_0000 : wr_pos_out + efd_pkg::WORD_BYTES;
   assign pos_adv = (user_pos_out + freed >= buf_len_in) ?
                    user_pos_out + freed - buf_len_in :
                    user_pos_out + freed;

   // Counters; a new transfer starts at byte 0 with the whole buffer free
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         wr_pos_out <= 32'h0000_0000;
         user_len_out <= 32'h0000_0000;
         user_pos_out <= 32'h0000_0000;
         pend_r <= 32'h0000_0000;
         free_r <= 32'h0000_0000;
      end else if (start_in) begin
         wr_pos_out <= 32'h0000_0000;
         user_len_out <= 32'h0000_0000;
         user_pos_out <= 32'h0000_0000;
         pend_r <= 32'h0000_0000;
         free_r <= buf_len_in;
      end else begin
         if (take_in) begin
            wr_pos_out <= wr_adv;
         end
         free_r <= free_r + freed -
                   (take_in ? efd_pkg::WORD_BYTES : 32'h0000_0000);
         pend_r <= pend_up - step;
         user_len_out <= user_len_out + step - freed;
         user_pos_out <= pos_adv;
      end
   end
endmodule // efd_ring_ch
`default_nettype wire

// ### hdl/efd_top.sv
// Purpose: Auxiliary FIFO to host ring transfer engine with commands
// Assumes: Host bridge adds the buffer base to dma_wr_out.pos
// Notes:   Independent of the main sample engine; shares command/status
//
// Summary of operation
// - Start bit begins DMA mode transfer
// - Wait ends on block, end or timeout
// - Stop bit aborts transfer, data invalid
// - Poll bit selects transfer without DMA
// - Block ready once notify bytes available
// - End flag only with zero notify size
// - Overrun flag on FIFO overflow while running
// - Error flag on internal transfer fault
// - Engine independent of main sample engine
// - One FIFO split into two kinds
// - One command write serves all engines
// - Card to host only, no offset
// - Start: user length zero, buffer free
// - User length moves in notify steps
// - Host returns consumed bytes to card
// - Position register per kind, read only
// - Zero notify reports only at end
// - Overrun halts the transfer at once
// - Poll read drains all available words
`timescale 1ns/10ps
`default_nettype none
module efd_top #(
   parameter int unsigned MS_CYCLES = efd_pkg::MS_CYCLES
) (
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wr_data_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rd_data_out,
   input wire efd_pkg::efd_word_t fifo_word_in,
   input wire logic fifo_valid_in,
   output logic fifo_ready_out,
   input wire logic fifo_overflow_in,
   input wire logic dma_fault_in,
   output efd_pkg::efd_wr_t dma_wr_out,
   input wire logic dma_ack_in,
   input wire logic [31:0] main_status_in,
   output logic [31:0] cmd_other_out,
   output logic wait_busy_out
);
   efd_pkg::efd_state_t state_r;
   efd_pkg::efd_state_t state_nxt;
   logic [31:0] buf_len_r [2];
   logic [31:0] notify_r;
   logic [31:0] timeout_r;
   logic done_r;
   logic ovr_r;
   logic err_r;
   logic valid_r;
   logic tmo_r;
   logic [31:0] pre_r;
   logic [31:0] ms_r;
   logic cmd_wr;
   logic start_c;
   logic stop_c;
   logic poll_c;
   logic wait_c;
   logic running;
   logic run_nxt;
   logic halt_ev;
   logic new_xfer;
   logic accept;
   logic land;
   logic done_ev;
   logic blk_rdy;
   logic expire;
   logic wait_done;
   logic out_busy_nxt;
   logic [31:0] rd_val;
   logic [31:0] wpos [2];
   logic [31:0] ulen [2];
   logic [31:0] upos [2];
   logic [31:0] dlen [2];
   logic [1:0] space;

   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!rstn_in);

   ////////////////////////////////////////////////////////////////////////
   // Command decode; aux bits act alone, other bits pass to the engines
   assign cmd_wr = wr_in && (addr_in == efd_pkg::CMD_IDX);
   assign stop_c = cmd_wr && wr_data_in[efd_pkg::STOP_BIT];
   assign start_c = cmd_wr && wr_data_in[efd_pkg::START_BIT] && !stop_c;
   // Start beats poll when both arrive; mixing is the host's fault
   assign poll_c = cmd_wr && wr_data_in[efd_pkg::POLL_BIT] && !stop_c &&
                   !wr_data_in[efd_pkg::START_BIT];
   assign wait_c = cmd_wr && wr_data_in[efd_pkg::WAIT_BIT];
   assign running = (state_r == efd_pkg::EFD_DMA) ||
                    (state_r == efd_pkg::EFD_POLL);
   assign run_nxt = (state_nxt == efd_pkg::EFD_DMA) ||
                    (state_nxt == efd_pkg::EFD_POLL);
   assign halt_ev = running && (fifo_overflow_in || dma_fault_in);
   assign new_xfer = (start_c || poll_c) && run_nxt;

   // Other command bits go on as a one-cycle pulse
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         cmd_other_out <= 32'h0000_0000;
      end else begin
         cmd_other_out <= cmd_wr ?
                          (wr_data_in & ~efd_pkg::CMD_AUX_MASK) :
                          32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transfer state; stop outranks a halt, which outranks a restart
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         efd_pkg::EFD_IDLE, efd_pkg::EFD_HALT: begin
            if (stop_c) begin
               state_nxt = efd_pkg::EFD_IDLE;
            end else if (start_c) begin
               state_nxt = efd_pkg::EFD_DMA;
            end else if (poll_c) begin
               state_nxt = efd_pkg::EFD_POLL;
            end
         end
         default: begin
            if (stop_c) begin
               state_nxt = efd_pkg::EFD_IDLE;
            end else if (halt_ev) begin
               state_nxt = efd_pkg::EFD_HALT;
            end else if (start_c) begin
               state_nxt = efd_pkg::EFD_DMA;
            end else if (poll_c) begin
               state_nxt = efd_pkg::EFD_POLL;
            end else if (done_ev) begin
               state_nxt = efd_pkg::EFD_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         state_r <= efd_pkg::EFD_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Configuration registers written by software
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         buf_len_r[0] <= efd_pkg::BUFLEN_RST;
         buf_len_r[1] <= efd_pkg::BUFLEN_RST;
         notify_r <= efd_pkg::NOTIFY_RST;
         timeout_r <= efd_pkg::TIMEOUT_RST;
      end else if (wr_in) begin
         if (addr_in == efd_pkg::SLOW_BUFLEN_IDX) begin
            buf_len_r[0] <= wr_data_in;
         end else if (addr_in == efd_pkg::STAMP_BUFLEN_IDX) begin
            buf_len_r[1] <= wr_data_in;
         end else if (addr_in == efd_pkg::NOTIFY_IDX) begin
            notify_r <= wr_data_in;
         end else if (addr_in == efd_pkg::TIMEOUT_IDX) begin
            timeout_r <= wr_data_in;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // FIFO to host write path; one write in flight keeps ordering simple
   assign accept = fifo_valid_in && fifo_ready_out;
   assign land = dma_ack_in && dma_wr_out.valid;
   assign done_ev = land && dma_wr_out.last;
   assign out_busy_nxt = accept || (dma_wr_out.valid && !dma_ack_in);

   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         dma_wr_out <= '0;
      end else if (stop_c || new_xfer || halt_ev) begin
         dma_wr_out.valid <= 1'b0;
      end else if (accept) begin
         dma_wr_out.valid <= 1'b1;
         dma_wr_out.kind <= fifo_word_in.kind;
         dma_wr_out.last <= fifo_word_in.last;
         dma_wr_out.pos <= wpos[fifo_word_in.kind];
         dma_wr_out.data <= fifo_word_in.data;
      end else if (dma_ack_in) begin
         dma_wr_out.valid <= 1'b0;
      end
   end

   // Ready only with room in both rings, since the next kind is unknown
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         fifo_ready_out <= 1'b0;
      end else begin
         fifo_ready_out <= run_nxt && !out_busy_nxt && !new_xfer &&
                           (&space);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // One ring per data kind, fed from the shared FIFO
   for (genvar g = 0; g < 2; g++) begin : g_ch
      efd_ring_ch u_ch (
         .ref_clk_in(ref_clk_in),
         .rstn_in(rstn_in),
         .start_in(new_xfer),
         .poll_in(state_r == efd_pkg::EFD_POLL),
         .take_in(accept && (fifo_word_in.kind == 1'(g))),
         .land_in(land && (dma_wr_out.kind == 1'(g))),
         .flush_in(done_ev),
         .drain_in(rd_in && (state_r == efd_pkg::EFD_POLL) &&
                   (addr_in == (g == 0 ? efd_pkg::SLOW_ULEN_IDX :
                                efd_pkg::STAMP_ULEN_IDX))),
         .free_in(wr_in &&
                  (addr_in == (g == 0 ? efd_pkg::SLOW_FREED_IDX :
                               efd_pkg::STAMP_FREED_IDX))),
         .buf_len_in(buf_len_r[g]),
         .notify_in(notify_r),
         .free_len_in(wr_data_in),
         .wr_pos_out(wpos[g]),
         .user_len_out(ulen[g]),
         .user_pos_out(upos[g]),
         .drain_len_out(dlen[g]),
         .space_out(space[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////
   // Status flags; a set in the clearing cycle wins
   assign blk_rdy = (state_r == efd_pkg::EFD_DMA) &&
                    (notify_r != 32'h0000_0000) &&
                    ((ulen[0] != 32'h0000_0000) ||
                     (ulen[1] != 32'h0000_0000));

   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         done_r <= 1'b0;
         ovr_r <= 1'b0;
         err_r <= 1'b0;
         valid_r <= 1'b0;
      end else begin
         if (done_ev && (notify_r == 32'h0000_0000)) begin
            done_r <= 1'b1;
         end else if (new_xfer) begin
            done_r <= 1'b0;
         end
         if (running && fifo_overflow_in) begin
            ovr_r <= 1'b1;
         end else if (new_xfer) begin
            ovr_r <= 1'b0;
         end
         if (running && dma_fault_in) begin
            err_r <= 1'b1;
         end else if (new_xfer) begin
            err_r <= 1'b0;
         end
         // Stop leaves the buffer contents undefined for software
         if (stop_c) begin
            valid_r <= 1'b0;
         end else if (new_xfer) begin
            valid_r <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Wait command; the bus never stalls, so waiting shows as a level
   assign expire = wait_busy_out && (timeout_r != 32'h0000_0000) &&
                   (pre_r == 32'(MS_CYCLES - 1)) &&
                   (ms_r + 32'h0000_0001 >= timeout_r);
   assign wait_done = blk_rdy || done_r || expire || !running;

   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         wait_busy_out <= 1'b0;
         tmo_r <= 1'b0;
         pre_r <= 32'h0000_0000;
         ms_r <= 32'h0000_0000;
      end else begin
         if (wait_c && !wait_done) begin
            wait_busy_out <= 1'b1;
         end else if (wait_done) begin
            wait_busy_out <= 1'b0;
         end
         if (expire) begin
            tmo_r <= 1'b1;
         end else if (wait_c) begin
            tmo_r <= 1'b0;
         end
         // Millisecond timebase runs only while waiting
         if (!wait_busy_out || wait_c) begin
            pre_r <= 32'h0000_0000;
            ms_r <= 32'h0000_0000;
         end else if (pre_r == 32'(MS_CYCLES - 1)) begin
            pre_r <= 32'h0000_0000;
            ms_r <= ms_r + 32'h0000_0001;
         end else begin
            pre_r <= pre_r + 32'h0000_0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read decode; main engine keeps its own status bits
   always_comb begin
      rd_val = 32'h0000_0000;
      if (addr_in == efd_pkg::STATUS_IDX) begin
         rd_val = main_status_in & ~efd_pkg::STAT_AUX_MASK;
         rd_val[efd_pkg::BLK_BIT] = blk_rdy;
         rd_val[efd_pkg::END_BIT] = done_r;
         rd_val[efd_pkg::OVR_BIT] = ovr_r;
         rd_val[efd_pkg::ERR_BIT] = err_r;
      end else if (addr_in == efd_pkg::SLOW_ULEN_IDX) begin
         rd_val = (state_r == efd_pkg::EFD_POLL) ? dlen[0] : ulen[0];
      end else if (addr_in == efd_pkg::SLOW_UPOS_IDX) begin
         rd_val = upos[0];
      end else if (addr_in == efd_pkg::STAMP_ULEN_IDX) begin
         rd_val = (state_r == efd_pkg::EFD_POLL) ? dlen[1] : ulen[1];
      end else if (addr_in == efd_pkg::STAMP_UPOS_IDX) begin
         rd_val = upos[1];
      end else if (addr_in == efd_pkg::SLOW_BUFLEN_IDX) begin
         rd_val = buf_len_r[0];
      end else if (addr_in == efd_pkg::STAMP_BUFLEN_IDX) begin
         rd_val = buf_len_r[1];
      end else if (addr_in == efd_pkg::NOTIFY_IDX) begin
         rd_val = notify_r;
      end else if (addr_in == efd_pkg::TIMEOUT_IDX) begin
         rd_val = timeout_r;
      end else if (addr_in == efd_pkg::AUX_STATE_IDX) begin
         rd_val = {26'h000_0000, state_r == efd_pkg::EFD_HALT, valid_r,
                   tmo_r, wait_busy_out, state_r == efd_pkg::EFD_POLL,
                   state_r == efd_pkg::EFD_DMA};
      end
   end

   // Read data stands for exactly one cycle, zero otherwise
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         rd_data_out <= 32'h0000_0000;
      end else begin
         rd_data_out <= rd_in ? rd_val : 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks on the engine's own behaviour
   property p_start;
      start_c && !halt_ev |=> state_r == efd_pkg::EFD_DMA && valid_r;
   endproperty
   a_start: assert property (p_start) else $error("start ignored");

   property p_wait;
      wait_busy_out && (blk_rdy || done_r) |=> !wait_busy_out;
   endproperty
   a_wait: assert property (p_wait) else $error("wait not ended");

   property p_stop;
      stop_c |=> state_r == efd_pkg::EFD_IDLE && !valid_r &&
                 !dma_wr_out.valid ##1 !fifo_ready_out;
   endproperty
   a_stop: assert property (p_stop) else $error("stop not taken");

   property p_poll;
      poll_c && !halt_ev |=> state_r == efd_pkg::EFD_POLL;
   endproperty
   a_poll: assert property (p_poll) else $error("poll ignored");

   property p_end_zero;
      $rose(done_r) |-> notify_r == 32'h0000_0000 && $past(done_ev);
   endproperty
   a_end_zero: assert property (p_end_zero) else $error("bad end");

   property p_overrun;
      running && fifo_overflow_in && !stop_c |=>
         ovr_r && state_r == efd_pkg::EFD_HALT && !fifo_ready_out;
   endproperty
   a_overrun: assert property (p_overrun) else $error("no halt");

   property p_fault;
      running && dma_fault_in |=> err_r;
   endproperty
   a_fault: assert property (p_fault) else $error("fault lost");

   property p_fresh;
      new_xfer |=> ulen[0] == 32'h0000_0000 &&
                   upos[1] == 32'h0000_0000 && wpos[0] == 32'h0000_0000;
   endproperty
   a_fresh: assert property (p_fresh) else $error("not cleared");

   property p_other;
      cmd_wr |=> cmd_other_out == ($past(wr_data_in) &
                                   ~efd_pkg::CMD_AUX_MASK);
   endproperty
   a_other: assert property (p_other) else $error("cmd lost");

   property p_room;
      fifo_ready_out |-> &space;
   endproperty
   a_room: assert property (p_room) else $error("ring overrun");

   property p_step;
      state_r == efd_pkg::EFD_DMA && $changed(ulen[0]) &&
      !$past(wr_in) |-> ulen[0] - $past(ulen[0]) == notify_r;
   endproperty
   a_step: assert property (p_step) else $error("odd step");

   c_dma: cover property (start_c ##[1:50] land);
   c_poll: cover property (poll_c ##[1:50] rd_in);
   c_done: cover property ($rose(done_r));
   c_tmo: cover property ($rose(tmo_r));
endmodule // efd_top
`default_nettype wire

// ### test/efd_host_model.sv
// Purpose: Host side sink that acknowledges ring buffer writes
// Assumes: One write in flight at a time, acknowledge is one cycle
// Notes:   Lag selects a prompt or a slow host
`timescale 1ns/10ps
`default_nettype none
module efd_host_model (
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   input wire efd_pkg::efd_wr_t wr_in,
   input wire logic [3:0] lag_in,
   output logic ack_out
);
   logic [3:0] wait_r;
   // One pulse per write, so no word is ever counted twice
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         wait_r <= 4'h0;
         ack_out <= 1'b0;
      end else begin
         ack_out <= 1'b0;
         if (wr_in.valid && !ack_out && wait_r >= lag_in) begin
            ack_out <= 1'b1;
            wait_r <= 4'h0;
         end else if (wr_in.valid && !ack_out) begin
            wait_r <= wait_r + 4'h1;
         end
      end
   end
endmodule // efd_host_model
`default_nettype wire

// ### test/efd_top_bench.sv
// Purpose: Self-checking bench of the auxiliary transfer engine
// Assumes: Short millisecond count, host model acknowledges writes
// Notes:   Main status is tied, so only aux bits can move
`timescale 1ns/10ps
`default_nettype none
module efd_top_bench;
   logic clk, rstn, wr, rd, fv, rdy, ovf, flt, ack, busy;
   logic [7:0] addr;
   logic [31:0] wd, rdat, other, co;
   logic [3:0] lag;
   efd_pkg::efd_word_t fw;
   efd_pkg::efd_wr_t dw;
   int fails, total_checks;
   efd_top #(.MS_CYCLES(4)) uut (.ref_clk_in(clk), .rstn_in(rstn),
      .addr_in(addr), .wr_data_in(wd), .wr_in(wr), .rd_in(rd),
      .rd_data_out(rdat), .fifo_word_in(fw), .fifo_valid_in(fv),
      .fifo_ready_out(rdy), .fifo_overflow_in(ovf), .dma_fault_in(flt),
      .dma_wr_out(dw), .dma_ack_in(ack), .main_status_in(32'h0000_0005),
      .cmd_other_out(other), .wait_busy_out(busy));
   efd_host_model host (.ref_clk_in(clk), .rstn_in(rstn), .wr_in(dw),
      .lag_in(lag), .ack_out(ack));
   ////////////////////////////////////////////////////////////////////////
   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Register write; the pulse outputs are caught in the following cycle
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(negedge clk);
      co = other;
   endtask
   // Register read; data stands only in the cycle after the strobe
   task automatic rreg(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk(rdat, e);
   endtask
   // One FIFO word; waits for ready, then for the host acknowledge
   // A wait that runs out is counted, so a stuck handshake cannot pass
   task automatic push(input logic k, input logic l, input logic [31:0] p);
      int n;
      @(posedge clk);
      fw <= '{kind: k, last: l, data: 32'h0000_00a5};
      fv <= 1'b1;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (rdy !== 1'b1 && n < 60);
      chk({31'h0, rdy}, 32'h0000_0001);
      @(posedge clk);
      fv <= 1'b0;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (ack !== 1'b1 && n < 60);
      chk({31'h0, ack}, 32'h0000_0001);
      chk(dw.pos, p);
      chk({30'h0, dw.kind, dw.last}, {30'h0, k, l});
      repeat (4) @(posedge clk);
   endtask
   task automatic pulse(input logic [1:0] w);
      @(posedge clk);
      {flt, ovf} <= w;
      @(posedge clk);
      {flt, ovf} <= 2'b00;
   endtask
   task automatic end_sim();
      if (fails == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Whole sequence needs well under a thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      end_sim();
   end
   initial begin
      {rstn, wr, rd, fv, ovf, flt, lag, addr, wd} = '0;
      fw = '0;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      rreg(efd_pkg::STATUS_IDX, 32'h0000_0005);
      rreg(8'h00, 32'h0000_0000);
      wreg(efd_pkg::SLOW_BUFLEN_IDX, 32'h0000_0010);
      wreg(efd_pkg::STAMP_BUFLEN_IDX, 32'h0000_0010);
      wreg(efd_pkg::NOTIFY_IDX, 32'h0000_0008);
      wreg(efd_pkg::CMD_IDX, 32'h0010_0001);
      chk(co, 32'h0000_0001);
      rreg(efd_pkg::AUX_STATE_IDX, 32'h0000_0011);
      rreg(efd_pkg::SLOW_ULEN_IDX, 32'h0000_0000);
      rreg(efd_pkg::CMD_IDX, 32'h0000_0000);
      wreg(efd_pkg::CMD_IDX, 32'h0020_0000);
      chk({31'h0, busy}, 32'h0000_0001);
      push(1'b0, 1'b0, 32'h0000_0000);
      rreg(efd_pkg::SLOW_ULEN_IDX, 32'h0000_0000);
      @(posedge clk);
      lag <= 4'h3;
      push(1'b0, 1'b0, 32'h0000_0004);
      chk({31'h0, busy}, 32'h0000_0000);
      rreg(efd_pkg::SLOW_ULEN_IDX, 32'h0000_0008);
      rreg(efd_pkg::STATUS_IDX, 32'h0000_1005);
      rreg(efd_pkg::SLOW_UPOS_IDX, 32'h0000_0000);
      wreg(efd_pkg::SLOW_FREED_IDX, 32'h0000_0008);
      push(1'b0, 1'b0, 32'h0000_0008);
      push(1'b0, 1'b0, 32'h0000_000c);
      rreg(efd_pkg::SLOW_UPOS_IDX, 32'h0000_0008);
      wreg(efd_pkg::SLOW_FREED_IDX, 32'h0000_0008);
      rreg(efd_pkg::SLOW_UPOS_IDX, 32'h0000_0000);
      pulse(2'b01);
      rreg(efd_pkg::STATUS_IDX, 32'h0000_4005);
      chk({31'h0, rdy}, 32'h0000_0000);
      wreg(efd_pkg::CMD_IDX, 32'h0010_0000);
      pulse(2'b10);
      rreg(efd_pkg::STATUS_IDX, 32'h0000_8005);
      // Zero notify size: only the end of the transfer is reported
      wreg(efd_pkg::NOTIFY_IDX, 32'h0000_0000);
      wreg(efd_pkg::CMD_IDX, 32'h0010_0000);
      push(1'b1, 1'b1, 32'h0000_0000);
      rreg(efd_pkg::STATUS_IDX, 32'h0000_2005);
      rreg(efd_pkg::STAMP_ULEN_IDX, 32'h0000_0004);
      rreg(efd_pkg::STAMP_UPOS_IDX, 32'h0000_0000);
      // Polling starts a fresh transfer, never mixed with DMA
      wreg(efd_pkg::CMD_IDX, 32'h0080_0000);
      push(1'b0, 1'b0, 32'h0000_0000);
      rreg(efd_pkg::SLOW_ULEN_IDX, 32'h0000_0004);
      rreg(efd_pkg::AUX_STATE_IDX, 32'h0000_0012);
      wreg(efd_pkg::CMD_IDX, 32'h0010_0000);
      // Wait with nothing to report gives up after one millisecond
      wreg(efd_pkg::TIMEOUT_IDX, 32'h0000_0001);
      wreg(efd_pkg::CMD_IDX, 32'h0020_0000);
      repeat (6) @(posedge clk);
      rreg(efd_pkg::AUX_STATE_IDX, 32'h0000_0019);
      wreg(efd_pkg::CMD_IDX, 32'h0040_0000);
      chk({31'h0, rdy}, 32'h0000_0000);
      rreg(efd_pkg::AUX_STATE_IDX, 32'h0000_0008);
      end_sim();
   end
endmodule // efd_top_bench
`default_nettype wire
